/* shared/ccr_pkg.sv */
// Package of the core control registers: offsets, field layouts, reset values, carriers
package ccr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] CCR_ADDR_TIMER = 8'h01;
  localparam logic [7:0] CCR_ADDR_PCL = 8'h02;
  localparam logic [7:0] CCR_ADDR_LATCH = 8'h0a;
  localparam logic [7:0] CCR_ADDR_LATCH_B1 = 8'h8a;
  localparam logic [7:0] CCR_ADDR_INTCTL = 8'h0b;
  localparam logic [7:0] CCR_ADDR_INTCTL_B1 = 8'h8b;
  localparam logic [7:0] CCR_ADDR_PFLAGS = 8'h0c;
  localparam logic [7:0] CCR_ADDR_PENABLE = 8'h8c;
  localparam logic [7:0] CCR_ADDR_OPTION = 8'h81;
  localparam logic [7:0] CCR_ADDR_RSTCAUSE = 8'h8e;
  localparam logic [7:0] CCR_ADDR_OSCTRIM = 8'h8f;

  // ==========================================================================
  // Reset values and the trim write mask
  localparam logic [7:0] CCR_OPTION_RST = 8'hff;
  localparam logic [7:0] CCR_INTCTL_RST = 8'h00;
  localparam logic [7:0] CCR_OSCTRIM_RST = 8'h70;
  localparam logic [7:0] CCR_OSCTRIM_MASK = 8'hfc;
  localparam logic [12:0] CCR_PC_RST = 13'h0000;

  // ==========================================================================
  // Field positions and widths
  localparam int CCR_RC_POR_BIT = 1;
  localparam int CCR_RC_WDT_BIT = 0;
  localparam int CCR_LATCH_W = 5;
  localparam int CCR_PC_W = 13;
  localparam int CCR_TARGET_W = 11;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CCR_RST_POR = 2'h0,
    CCR_RST_MASTER_CLEAR = 2'h1,
    CCR_RST_WDT = 2'h3
  } ccr_rst_kind_t;

  typedef struct packed {
    logic pullup_disable;
    logic ext_irq_edge_select;
    logic timer_clock_source_select;
    logic timer_source_edge_select;
    logic prescaler_assign;
    logic [2:0] prescaler_rate;
  } ccr_option_t;

  typedef struct packed {
    logic global_irq_enable;
    logic peripheral_irq_enable;
    logic timer_overflow_enable;
    logic ext_irq_enable;
    logic port_change_enable;
    logic timer_overflow_flag;
    logic ext_irq_flag;
    logic port_change_flag;
  } ccr_intctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ccr_bus_req_t;

  typedef struct packed {
    logic inc;
    logic branch;
    logic [10:0] target;
  } ccr_core_req_t;

endpackage : ccr_pkg

/* hw/ccr_core_control.sv */
// Core control registers: timer/prescaler options, interrupt control, reset cause, trim, program counter
//
// Contract
// - Ext interrupt edge select 1 means rising pin edge, 0 means falling.
// - Timer source select 1 counts pin transitions, 0 counts instruction cycles.
// - Timer source edge 1 counts high-to-low, 0 counts low-to-high pin transitions.
// - Prescaler assign set gives prescaler to watchdog; timer then runs 1:1.
// - Rate field 000 divides timer by 2, doubling per code up to 256.
// - Flags set on their condition regardless of own or global enable.
// - Global enable passes unmasked interrupts; cleared blocks all interrupts.
// - Peripheral interrupts need the peripheral enable bit, bit 6.
// - Timer overflow sets sticky flag until software clears; enable gates it.
// - Selected ext pin edge sets sticky flag until cleared; enable gates it.
// - Any of three watched pins changing sets sticky flag; enable gates it.
// - Interrupt control register appears at both bank addresses.
// - Reset cause register tells power-on from master-clear and watchdog resets.
// - Trim register holds four fine bits plus raise and lower bits.
// - Program counter is 13 bits; only low byte is software visible.
// - Any reset clears the whole program counter.
// - Writing low byte loads upper bits from latch bits 4 to 0.
// - Call or jump takes top two bits from latch bits 4 and 3.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

module ccr_core_control
  import ccr_pkg::*;
#(
  parameter int NUM_CHG = 3,
  parameter int NUM_PERIPH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire ccr_rst_kind_t rst_kind,
  // Register port
  input wire ccr_bus_req_t bus_req,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic shared_timer_irq_pin,
  input wire logic [NUM_CHG-1:0] change_pins,
  // Peripheral events and watchdog tick
  input wire logic [NUM_PERIPH-1:0] periph_events,
  input wire logic watchdog_tick,
  // Core side
  input wire ccr_core_req_t core_req,
  output logic [CCR_PC_W-1:0] pc,
  output logic irq_to_core,
  output logic watchdog_expire,
  output logic [5:0] osc_trim,
  output logic pullup_disable
);

  // ==========================================================================
  // Pin synchronisers and edge detection
  logic pin_s1_r, pin_s2_r, pin_d_r;
  logic [NUM_CHG-1:0] chg_s1_r, chg_s2_r, chg_d_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
      chg_s1_r <= '0;
      chg_s2_r <= '0;
      chg_d_r <= '0;
    end else begin
      pin_s1_r <= shared_timer_irq_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
      chg_s1_r <= change_pins;
      chg_s2_r <= chg_s1_r;
      chg_d_r <= chg_s2_r;
    end
  end

  logic pin_rise, pin_fall, chg_any;
  assign pin_rise = pin_s2_r & ~pin_d_r;
  assign pin_fall = ~pin_s2_r & pin_d_r;
  assign chg_any = |(chg_s2_r ^ chg_d_r);

  // ==========================================================================
  // Register state
  ccr_option_t option_r;
  ccr_intctl_t intctl_r;
  logic [7:0] timer_r;
  logic [7:0] pre_r;
  logic [CCR_LATCH_W-1:0] latch_r;
  logic [NUM_PERIPH-1:0] pflags_r, penable_r;
  logic [1:0] rstcause_r;
  logic [7:0] osctrim_r;
  logic [CCR_PC_W-1:0] pc_r;

  logic wr_timer, wr_pcl, wr_latch, wr_intctl, wr_pflags, wr_penable, wr_option, wr_rst, wr_osc;
  assign wr_timer = bus_req.wr && bus_req.addr == CCR_ADDR_TIMER;
  assign wr_pcl = bus_req.wr && bus_req.addr == CCR_ADDR_PCL;
  assign wr_latch = bus_req.wr && (bus_req.addr == CCR_ADDR_LATCH || bus_req.addr == CCR_ADDR_LATCH_B1);
  assign wr_intctl = bus_req.wr && (bus_req.addr == CCR_ADDR_INTCTL || bus_req.addr == CCR_ADDR_INTCTL_B1);
  assign wr_pflags = bus_req.wr && bus_req.addr == CCR_ADDR_PFLAGS;
  assign wr_penable = bus_req.wr && bus_req.addr == CCR_ADDR_PENABLE;
  assign wr_option = bus_req.wr && bus_req.addr == CCR_ADDR_OPTION;
  assign wr_rst = bus_req.wr && bus_req.addr == CCR_ADDR_RSTCAUSE;
  assign wr_osc = bus_req.wr && bus_req.addr == CCR_ADDR_OSCTRIM;

  // ==========================================================================
  // Timer source, prescaler and watchdog share
  logic ext_edge, src_edge, tmr_evt, pre_evt, div_tick, tmr_tick, tmr_ovf;
  logic [3:0] pre_shift;
  logic [8:0] pre_mask9;
  logic [7:0] pre_nxt;

  assign ext_edge = option_r.ext_irq_edge_select ? pin_rise : pin_fall;
  assign src_edge = option_r.timer_source_edge_select ? pin_fall : pin_rise;
  assign tmr_evt = option_r.timer_clock_source_select ? src_edge : 1'b1;
  assign pre_evt = option_r.prescaler_assign ? watchdog_tick : tmr_evt;
  assign pre_shift = option_r.prescaler_assign ? {1'b0, option_r.prescaler_rate}
                                               : {1'b0, option_r.prescaler_rate} + 4'h1;
  assign pre_mask9 = (9'h001 << pre_shift) - 9'h001;
  assign pre_nxt = pre_r + 8'h01;
  assign div_tick = pre_evt && ((pre_nxt & pre_mask9[7:0]) == 8'h00);
  assign tmr_tick = option_r.prescaler_assign ? tmr_evt : div_tick;
  assign tmr_ovf = tmr_tick && !wr_timer && timer_r == 8'hff;

  always_ff @(posedge clk) begin
    if (sys_rst || wr_timer) begin
      pre_r <= 8'h00;
    end else if (pre_evt) begin
      pre_r <= pre_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_r <= 8'h00;
    end else if (wr_timer) begin
      timer_r <= bus_req.wdata;
    end else if (tmr_tick) begin
      timer_r <= timer_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      watchdog_expire <= 1'b0;
    end else begin
      watchdog_expire <= option_r.prescaler_assign ? div_tick : watchdog_tick;
    end
  end

  // ==========================================================================
  // Option register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      option_r <= CCR_OPTION_RST;
    end else if (wr_option) begin
      option_r <= bus_req.wdata;
    end
  end

  assign pullup_disable = option_r.pullup_disable;

  // ==========================================================================
  // Interrupt control: sticky flags, set wins over a clearing write
  logic [7:0] iw;
  assign iw = bus_req.wdata;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intctl_r <= CCR_INTCTL_RST;
    end else if (wr_intctl) begin
      intctl_r <= {iw[7:3], iw[2] | tmr_ovf, iw[1] | ext_edge, iw[0] | chg_any};
    end else begin
      intctl_r.timer_overflow_flag <= intctl_r.timer_overflow_flag | tmr_ovf;
      intctl_r.ext_irq_flag <= intctl_r.ext_irq_flag | ext_edge;
      intctl_r.port_change_flag <= intctl_r.port_change_flag | chg_any;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pflags_r <= '0;
    end else if (wr_pflags) begin
      pflags_r <= bus_req.wdata[NUM_PERIPH-1:0] | periph_events;
    end else begin
      pflags_r <= pflags_r | periph_events;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      penable_r <= '0;
    end else if (wr_penable) begin
      penable_r <= bus_req.wdata[NUM_PERIPH-1:0];
    end
  end

  logic core_pend, periph_pend;
  assign core_pend = (intctl_r.timer_overflow_enable && intctl_r.timer_overflow_flag)
                  || (intctl_r.ext_irq_enable && intctl_r.ext_irq_flag)
                  || (intctl_r.port_change_enable && intctl_r.port_change_flag);
  assign periph_pend = intctl_r.peripheral_irq_enable && |(pflags_r & penable_r);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_to_core <= 1'b0;
    end else begin
      irq_to_core <= intctl_r.global_irq_enable && (core_pend || periph_pend);
    end
  end

  // ==========================================================================
  // Reset cause and oscillator trim
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unique case (rst_kind)
        CCR_RST_POR: rstcause_r <= 2'h1;
        CCR_RST_WDT: rstcause_r <= {rstcause_r[CCR_RC_POR_BIT], 1'b0};
        default: rstcause_r <= rstcause_r;
      endcase
    end else if (wr_rst) begin
      rstcause_r <= bus_req.wdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osctrim_r <= CCR_OSCTRIM_RST;
    end else if (wr_osc) begin
      osctrim_r <= bus_req.wdata & CCR_OSCTRIM_MASK;
    end
  end

  assign osc_trim = osctrim_r[7:2];

  // ==========================================================================
  // Program counter and high latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_r <= '0;
    end else if (wr_latch) begin
      latch_r <= bus_req.wdata[CCR_LATCH_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_r <= CCR_PC_RST;
    end else if (wr_pcl) begin
      pc_r <= {latch_r, bus_req.wdata};
    end else if (core_req.branch) begin
      pc_r <= {latch_r[4:3], core_req.target};
    end else if (core_req.inc) begin
      pc_r <= pc_r + 13'h0001;
    end
  end

  assign pc = pc_r;

  // ==========================================================================
  // Read port
  always_ff @(posedge clk) begin
    if (sys_rst || !bus_req.rd) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (bus_req.addr)
        CCR_ADDR_TIMER: reg_rdata <= timer_r;
        CCR_ADDR_PCL: reg_rdata <= pc_r[7:0];
        CCR_ADDR_LATCH, CCR_ADDR_LATCH_B1: reg_rdata <= {3'h0, latch_r};
        CCR_ADDR_INTCTL, CCR_ADDR_INTCTL_B1: reg_rdata <= intctl_r;
        CCR_ADDR_PFLAGS: reg_rdata <= 8'(pflags_r);
        CCR_ADDR_PENABLE: reg_rdata <= 8'(penable_r);
        CCR_ADDR_OPTION: reg_rdata <= option_r;
        CCR_ADDR_RSTCAUSE: reg_rdata <= {6'h00, rstcause_r};
        CCR_ADDR_OSCTRIM: reg_rdata <= osctrim_r;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ext_edge_flag: assert property (ext_edge |=> intctl_r.ext_irq_flag)
    else $error("selected edge did not set external flag");
  a_internal_count: assert property ((!option_r.timer_clock_source_select && option_r.prescaler_assign
      && !wr_timer && !wr_option) |=> timer_r == $past(timer_r) + 8'h01)
    else $error("internal clock did not advance timer");
  a_pin_src_hold: assert property ((option_r.timer_clock_source_select && option_r.prescaler_assign
      && !src_edge && !wr_timer) |=> timer_r == $past(timer_r))
    else $error("timer moved without selected pin edge");
  a_div_two: assert property ((option_r == 8'h00 && tmr_tick && !wr_option && !wr_timer) |=> !tmr_tick)
    else $error("1:2 prescale ticked twice in a row");
  a_wdt_share: assert property (!option_r.prescaler_assign |=> watchdog_expire == $past(watchdog_tick))
    else $error("watchdog tick lost while prescaler with timer");
  a_ovf_flag_set: assert property (tmr_ovf |=> intctl_r.timer_overflow_flag)
    else $error("timer overflow did not set flag");
  a_flag_sticky: assert property ((intctl_r.timer_overflow_flag && !wr_intctl) |=> intctl_r.timer_overflow_flag)
    else $error("timer flag cleared without write");
  a_chg_flag_set: assert property (chg_any |=> intctl_r.port_change_flag)
    else $error("pin change did not set flag");
  a_gie_block: assert property (!intctl_r.global_irq_enable |=> !irq_to_core)
    else $error("interrupt passed with global enable clear");
  a_gie_pass: assert property ((intctl_r.global_irq_enable && core_pend) |=> irq_to_core)
    else $error("unmasked interrupt not delivered");
  a_peripheral_irq_enable_gate: assert property ((!intctl_r.peripheral_irq_enable && !core_pend) |=> !irq_to_core)
    else $error("peripheral interrupt passed without enable");
  a_intctl_alias: assert property ((bus_req.rd && bus_req.addr == CCR_ADDR_INTCTL_B1)
      |=> reg_rdata == $past(intctl_r))
    else $error("second bank read of interrupt control wrong");
  a_pcl_load: assert property (wr_pcl |=> pc_r == {$past(latch_r), $past(bus_req.wdata)})
    else $error("low byte write did not load from latch");
  a_branch_load: assert property ((core_req.branch && !wr_pcl)
      |=> pc_r == {$past(latch_r[4:3]), $past(core_req.target)})
    else $error("branch loaded wrong target");
  a_pc_reset: assert property (@(posedge clk) disable iff (1'b0) sys_rst |=> pc_r == CCR_PC_RST)
    else $error("reset did not clear program counter");

  c_ext_irq: cover property (intctl_r.global_irq_enable && intctl_r.ext_irq_enable && ext_edge ##2 irq_to_core);
  c_timer_ovf: cover property (tmr_ovf ##1 intctl_r.timer_overflow_flag);
  c_pcl_write: cover property (wr_pcl ##1 bus_req.rd && bus_req.addr == CCR_ADDR_PCL);
  c_set_clear_race: cover property (wr_intctl && !iw[1] && ext_edge);

endmodule : ccr_core_control

/* sim/ccr_core_model.sv */
// Partner model: CPU core issuing jumps and the interrupt sources around the block
`timescale 1ns/1ps

module ccr_core_model
  import ccr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Toward the block
  output ccr_core_req_t core_req,
  output logic [7:0] periph_events,
  output logic [2:0] change_pins,
  output logic timer_pin
);
  initial begin
    core_req = '0;
    periph_events = 8'h00;
    change_pins = 3'h0;
    timer_pin = 1'b0;
  end

  // ==========================================================================
  // Core: one-cycle jump request with an 11-bit address field
  task automatic branch(input logic [10:0] t);
    @(posedge clk);
    core_req <= '{inc: 1'b0, branch: 1'b1, target: t};
    @(posedge clk);
    core_req <= '0;
  endtask : branch

  // ==========================================================================
  // Sources: one-cycle peripheral event, pin levels held until changed
  task automatic periph_pulse(input logic [7:0] m);
    @(posedge clk);
    periph_events <= m;
    @(posedge clk);
    periph_events <= 8'h00;
  endtask : periph_pulse

  task automatic set_pin(input logic v, input int hold);
    @(posedge clk);
    timer_pin <= v;
    repeat (hold) @(posedge clk);
  endtask : set_pin

  task automatic set_change(input logic [2:0] v);
    @(posedge clk);
    change_pins <= v;
  endtask : set_change
endmodule : ccr_core_model

/* sim/ccr_core_control_test.sv */
// Testbench of the core control registers
`timescale 1ns/1ps

module ccr_core_control_test
  import ccr_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  ccr_rst_kind_t rst_kind = CCR_RST_POR;
  ccr_bus_req_t bus_req = '0;
  logic [7:0] reg_rdata;
  logic [12:0] pc;
  logic irq_to_core;
  logic [5:0] osc_trim;
  logic pullup_disable;
  ccr_core_req_t core_req;
  logic [7:0] periph_events;
  logic [2:0] change_pins;
  logic timer_pin;
  logic wd_tick = 1'b0;
  logic wd_exp;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] d;

  always #12.5 clk = ~clk;

  ccr_core_model model_u (.clk(clk), .core_req(core_req), .periph_events(periph_events),
    .change_pins(change_pins), .timer_pin(timer_pin));

  ccr_core_control dut_u (.clk(clk), .sys_rst(sys_rst), .rst_kind(rst_kind), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .shared_timer_irq_pin(timer_pin), .change_pins(change_pins),
    .periph_events(periph_events), .watchdog_tick(wd_tick), .core_req(core_req), .pc(pc),
    .irq_to_core(irq_to_core), .watchdog_expire(wd_exp), .osc_trim(osc_trim), .pullup_disable(pullup_disable));

  // ==========================================================================
  // Bus tasks and compare
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, v});
  endtask : rdchk

  task automatic do_reset(input ccr_rst_kind_t k);
    @(posedge clk);
    rst_kind <= k;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Tests
  initial begin
    do_reset(CCR_RST_POR);
    #1 chk("pc", 16'h0000, {3'h0, pc});
    chk("trim out", 16'h001c, {10'h0, osc_trim});
    chk("pullup", 16'h0001, {15'h0, pullup_disable});
    rdchk(CCR_ADDR_OPTION, CCR_OPTION_RST);
    rdchk(CCR_ADDR_INTCTL, CCR_INTCTL_RST);
    rdchk(CCR_ADDR_RSTCAUSE, 8'h01);
    rdchk(8'h50, 8'h00);
    wr(CCR_ADDR_OSCTRIM, 8'hab);
    rdchk(CCR_ADDR_OSCTRIM, 8'ha8);
    #1 chk("trim out", 16'h002a, {10'h0, osc_trim});
    wr(CCR_ADDR_INTCTL, 8'h30);
    rdchk(CCR_ADDR_INTCTL_B1, 8'h30);
    wr(CCR_ADDR_INTCTL_B1, 8'h00);
    rdchk(CCR_ADDR_INTCTL, 8'h00);
    // Program counter loading
    wr(CCR_ADDR_LATCH, 8'h15);
    wr(CCR_ADDR_PCL, 8'h34);
    #1 chk("pc", 16'h1534, {3'h0, pc});
    rdchk(CCR_ADDR_PCL, 8'h34);
    wr(CCR_ADDR_LATCH_B1, 8'h18);
    model_u.branch(11'h123);
    #1 chk("pc", 16'h1923, {3'h0, pc});
    // Computed jump past a page end keeps the latch page
    wr(CCR_ADDR_LATCH, 8'h03);
    wr(CCR_ADDR_PCL, 8'hfe);
    wr(CCR_ADDR_PCL, 8'h05);
    #1 chk("pc", 16'h0305, {3'h0, pc});
    // Watchdog tick passes with or without the prescaler at rate code 0
    for (int w = 0; w < 2; w++) begin
      wr(CCR_ADDR_OPTION, w ? 8'h08 : 8'h20);
      @(posedge clk);
      wd_tick <= 1'b1;
      @(posedge clk);
      wd_tick <= 1'b0;
      #1 chk("wdt expire", 16'h0001, {15'h0, wd_exp});
    end
    // Reset cause for master-clear and watchdog resets; clearing of pc after master clear only
    wr(CCR_ADDR_RSTCAUSE, 8'h02);
    do_reset(CCR_RST_MASTER_CLEAR);
    #1 chk("pc", 16'h0000, {3'h0, pc});
    rdchk(CCR_ADDR_RSTCAUSE, 8'h02);
    wr(CCR_ADDR_RSTCAUSE, 8'h03);
    do_reset(CCR_RST_WDT);
    rdchk(CCR_ADDR_RSTCAUSE, 8'h02);
    // Prescaler rates: timer rate 2^(code+1), or 1:1 with watchdog assignment
    for (int r = 0; r < 9; r++) begin
      wr(CCR_ADDR_OPTION, (r == 8) ? 8'h08 : 8'(r));
      wr(CCR_ADDR_TIMER, 8'h00);
      repeat (((r == 8) ? 1 : (2 << r)) * 4 - 2) @(posedge clk);
      rd(CCR_ADDR_TIMER, d);
      chk("timer rate", 16'h0001, {15'h0, (d >= 8'd3 && d <= 8'd5)});
    end
    // Pin-clocked timer on each edge
    for (int e = 0; e < 2; e++) begin
      wr(CCR_ADDR_OPTION, e ? 8'h38 : 8'h28);
      wr(CCR_ADDR_TIMER, 8'h00);
      repeat (3) begin
        model_u.set_pin(1'b1, 4);
        model_u.set_pin(1'b0, 4);
      end
      rdchk(CCR_ADDR_TIMER, 8'h03);
    end
    // External interrupt edge and sticky flag
    for (int e = 0; e < 2; e++) begin
      wr(CCR_ADDR_OPTION, e ? 8'h48 : 8'h08);
      wr(CCR_ADDR_INTCTL, 8'h00);
      model_u.set_pin(1'b1, 8);
      rd(CCR_ADDR_INTCTL, d);
      chk("ext flag rise", {15'h0, e[0]}, {15'h0, d[1]});
      wr(CCR_ADDR_INTCTL, 8'h00);
      model_u.set_pin(1'b0, 8);
      repeat (10) @(posedge clk);
      rd(CCR_ADDR_INTCTL, d);
      chk("ext flag fall", {15'h0, ~e[0]}, {15'h0, d[1]});
    end
    wr(CCR_ADDR_INTCTL, 8'h92);
    repeat (3) @(posedge clk);
    #1 chk("irq ext", 16'h0001, {15'h0, irq_to_core});
    // Timer overflow flag, gated by its enable and the global enable
    wr(CCR_ADDR_INTCTL, 8'h00);
    wr(CCR_ADDR_TIMER, 8'hfe);
    repeat (20) @(posedge clk);
    rd(CCR_ADDR_INTCTL, d);
    chk("ovf flag", 16'h0001, {15'h0, d[2]});
    chk("irq off", 16'h0000, {15'h0, irq_to_core});
    wr(CCR_ADDR_INTCTL, 8'h84);
    repeat (3) @(posedge clk);
    #1 chk("irq no enable", 16'h0000, {15'h0, irq_to_core});
    wr(CCR_ADDR_INTCTL, 8'ha4);
    repeat (3) @(posedge clk);
    #1 chk("irq ovf", 16'h0001, {15'h0, irq_to_core});
    wr(CCR_ADDR_INTCTL, 8'h24);
    repeat (3) @(posedge clk);
    #1 chk("irq global off", 16'h0000, {15'h0, irq_to_core});
    // Port change flag
    wr(CCR_ADDR_OPTION, 8'h28);
    wr(CCR_ADDR_INTCTL, 8'h00);
    model_u.set_change(3'h4);
    repeat (8) @(posedge clk);
    rd(CCR_ADDR_INTCTL, d);
    chk("change flag", 16'h0001, {15'h0, d[0]});
    wr(CCR_ADDR_INTCTL, 8'h89);
    repeat (3) @(posedge clk);
    #1 chk("irq change", 16'h0001, {15'h0, irq_to_core});
    // Peripheral interrupt needs the peripheral enable
    wr(CCR_ADDR_INTCTL, 8'h00);
    wr(CCR_ADDR_PFLAGS, 8'h00);
    wr(CCR_ADDR_PENABLE, 8'h01);
    wr(CCR_ADDR_INTCTL, 8'h80);
    model_u.periph_pulse(8'h01);
    repeat (3) @(posedge clk);
    rdchk(CCR_ADDR_PFLAGS, 8'h01);
    chk("irq no periph", 16'h0000, {15'h0, irq_to_core});
    wr(CCR_ADDR_INTCTL, 8'hc0);
    repeat (3) @(posedge clk);
    #1 chk("irq periph", 16'h0001, {15'h0, irq_to_core});
    finish_test();
  end
endmodule : ccr_core_control_test
